// File: common/bsd_consts.vh
`ifndef BSD_CONSTS_VH
`define BSD_CONSTS_VH

// ----------------------------------------------------------------------------
// Register port addresses
// ----------------------------------------------------------------------------
`define BSD_ADDR_DRAM_TIMING 16'h4072
`define BSD_ADDR_SHADOW_CTRL 16'h6072
`define BSD_ADDR_BOUNDARY 16'hC072

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define BSD_RST_DRAM_TIMING 16'h0000
`define BSD_RST_SHADOW_CTRL 16'h0004
`define BSD_RST_BOUNDARY 8'h00

// ----------------------------------------------------------------------------
// Field positions, dram_nonpage_timing
// ----------------------------------------------------------------------------
`define BSD_TM_MODE_HI 14
`define BSD_TM_MODE_LO 13
`define BSD_TM_RAW 12
`define BSD_TM_WCAS_HI 11
`define BSD_TM_WCAS_LO 10
`define BSD_TM_RCAS_HI 9
`define BSD_TM_RCAS_LO 8
`define BSD_TM_HOLD_HI 6
`define BSD_TM_HOLD_LO 5
`define BSD_TM_PWE_HI 4
`define BSD_TM_PWE_LO 2
`define BSD_TM_WS_HI 1
`define BSD_TM_WS_LO 0
`define BSD_TM_MASK 16'h7F7F

// ----------------------------------------------------------------------------
// Field positions, ram_shadow_protect_ctrl
// ----------------------------------------------------------------------------
`define BSD_SC_UPPER_WP 13
`define BSD_SC_SHADOW_WP 12
`define BSD_SC_SHD_HI 9
`define BSD_SC_SHD_LO 8
`define BSD_SC_XMEM 7
`define BSD_SC_VB_HI 5
`define BSD_SC_VB_LO 4
`define BSD_SC_ROM_HI 3
`define BSD_SC_ROM_LO 2
`define BSD_SC_MOU_HI 1
`define BSD_SC_MOU_LO 0
`define BSD_SC_MASK_LP 16'hFFBF
`define BSD_SC_MASK_STD 16'hFFBC

// ----------------------------------------------------------------------------
// Chip-select codes and mode encodings
// ----------------------------------------------------------------------------
`define BSD_CS_BOOT_ROM 5'h00
`define BSD_CS_DRAM 5'h01
`define BSD_CS_NONE 5'h1F
`define BSD_NONPAGE_TIMING_MODE_ONE_WAIT 2'h0
`define BSD_NONPAGE_TIMING_MODE_ZERO_WAIT 2'h1

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BSD_CLK_HZ 100000000
`define BSD_BOOST_SECONDS 1
`define BSD_BOOST_CYCLES (`BSD_BOOST_SECONDS * `BSD_CLK_HZ)
`define BSD_TAP_W 6

`endif

// File: src/bsd_delay_line.v
`timescale 1ns/1ps
`include "bsd_consts.vh"

module bsd_delay_line (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_srst,
  input wire i_clk_en,
  // Reference and strobe
  input wire i_ref_clk_14m,
  input wire i_strobe,
  // RAS request and tuned tap
  output reg o_ras,
  output reg [`BSD_TAP_W-1:0] o_tap
);

  reg ref_q;
  reg [`BSD_TAP_W-1:0] half_cnt;
  reg [`BSD_TAP_W-1:0] delay_cnt;
  wire ref_edge;

  assign ref_edge = i_ref_clk_14m ^ ref_q;

  // ----------------------------------------------------------------------------
  // Self tuning: tap is one less than the clock count of one reference half period
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      ref_q <= 1'b0;
      half_cnt <= {`BSD_TAP_W{1'b0}};
      o_tap <= {{(`BSD_TAP_W-1){1'b0}}, 1'b1};
    end else if (i_clk_en) begin
      ref_q <= i_ref_clk_14m;
      if (ref_edge) begin
        half_cnt <= {`BSD_TAP_W{1'b0}};
        if (half_cnt != {`BSD_TAP_W{1'b0}}) begin
          o_tap <= half_cnt;
        end
      end else if (half_cnt != {`BSD_TAP_W{1'b1}}) begin
        half_cnt <= half_cnt + {{(`BSD_TAP_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------------------
  // RAS leading edge a fixed delay after the strobe goes active
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      delay_cnt <= {`BSD_TAP_W{1'b0}};
      o_ras <= 1'b0;
    end else if (i_clk_en) begin
      if (!i_strobe) begin
        delay_cnt <= {`BSD_TAP_W{1'b0}};
        o_ras <= 1'b0;
      end else if (delay_cnt >= o_tap) begin
        o_ras <= 1'b1;
      end else begin
        delay_cnt <= delay_cnt + {{(`BSD_TAP_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // bsd_delay_line

// File: src/bsd_shadow_decode.v
`timescale 1ns/1ps
`include "bsd_consts.vh"

module bsd_shadow_decode #(
  parameter LOW_POWER_VARIANT = 1,
  parameter [31:0] BOOST_CYCLES = `BSD_BOOST_CYCLES
) (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_srst,
  input wire i_clk_en,
  // I/O register port
  input wire [15:0] i_io_addr,
  input wire i_io_wr,
  input wire i_io_rd,
  input wire [15:0] i_io_wdata,
  output reg [15:0] o_io_rdata,
  output reg o_io_rdata_valid,
  // Memory cycle request
  input wire i_mem_start,
  input wire [23:0] i_mem_addr,
  input wire i_mem_write,
  input wire i_mem_ems,
  input wire i_mem_ilv_miss,
  // Memory cycle decode
  output reg o_decode_valid,
  output reg [4:0] o_chip_sel,
  output reg [16:0] o_rom_addr,
  output reg o_isa_route,
  output reg o_write_block,
  output reg [2:0] o_wait_states,
  output reg o_row_hold_half,
  output reg [15:0] o_timing_fields,
  // DMA and bus-master timing
  input wire i_memr_active,
  input wire i_memw_active,
  input wire i_ref_clk_14m,
  output reg o_dma_ras,
  // Mouse activity
  input wire i_mouse_int12,
  input wire i_mouse_int4,
  input wire i_mouse_int3,
  input wire i_auto_speed_switch,
  output reg o_speed_boost,
  output reg o_mouse_activity
);

  reg [15:0] dram_nonpage_timing;
  reg [15:0] ram_shadow_protect_ctrl;
  reg [7:0] high_mem_protect_boundary;
  reg last_was_write;
  reg mouse_q;
  reg [31:0] boost_cnt;

  wire [1:0] nonpage_timing_mode;
  wire read_after_write_nowait;
  wire [1:0] added_wait_states;
  wire upper_protect_enable;
  wire shadow_wp;
  wire [1:0] shadow_select;
  wire spare_ram;
  wire [1:0] video_bios_size;
  wire [1:0] rom_layout_select;
  wire [1:0] mouse_wake_select;
  wire [15:0] sc_mask;
  wire ras_raw;
  wire [`BSD_TAP_W-1:0] tap_unused;

  assign nonpage_timing_mode = dram_nonpage_timing[`BSD_TM_MODE_HI:`BSD_TM_MODE_LO];
  assign read_after_write_nowait = dram_nonpage_timing[`BSD_TM_RAW];
  assign added_wait_states = dram_nonpage_timing[`BSD_TM_WS_HI:`BSD_TM_WS_LO];
  assign upper_protect_enable = ram_shadow_protect_ctrl[`BSD_SC_UPPER_WP];
  assign shadow_wp = ram_shadow_protect_ctrl[`BSD_SC_SHADOW_WP];
  assign shadow_select = ram_shadow_protect_ctrl[`BSD_SC_SHD_HI:`BSD_SC_SHD_LO];
  assign spare_ram = ram_shadow_protect_ctrl[`BSD_SC_XMEM];
  assign video_bios_size = ram_shadow_protect_ctrl[`BSD_SC_VB_HI:`BSD_SC_VB_LO];
  assign rom_layout_select = ram_shadow_protect_ctrl[`BSD_SC_ROM_HI:`BSD_SC_ROM_LO];
  assign mouse_wake_select = ram_shadow_protect_ctrl[`BSD_SC_MOU_HI:`BSD_SC_MOU_LO];
  assign sc_mask = (LOW_POWER_VARIANT != 0) ? `BSD_SC_MASK_LP : `BSD_SC_MASK_STD;

  // ----------------------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------------------
  // Timing changes on the very next cycle, so code running from shadow RAM
  // may be caught mid-change; boot code must program it from ROM.
  always @(posedge i_clk) begin
    if (i_srst) begin
      dram_nonpage_timing <= `BSD_RST_DRAM_TIMING;
      ram_shadow_protect_ctrl <= `BSD_RST_SHADOW_CTRL;
      high_mem_protect_boundary <= `BSD_RST_BOUNDARY;
      o_io_rdata <= 16'h0000;
      o_io_rdata_valid <= 1'b0;
    end else if (i_clk_en) begin
      o_io_rdata_valid <= i_io_rd;
      if (i_io_wr) begin
        case (i_io_addr)
          `BSD_ADDR_DRAM_TIMING: begin
            dram_nonpage_timing <= i_io_wdata & `BSD_TM_MASK;
          end
          `BSD_ADDR_SHADOW_CTRL: begin
            ram_shadow_protect_ctrl <= i_io_wdata & sc_mask;
          end
          `BSD_ADDR_BOUNDARY: begin
            high_mem_protect_boundary <= i_io_wdata[7:0];
          end
          default: begin
          end
        endcase
      end
      if (i_io_rd) begin
        case (i_io_addr)
          `BSD_ADDR_DRAM_TIMING: o_io_rdata <= dram_nonpage_timing;
          `BSD_ADDR_SHADOW_CTRL: o_io_rdata <= ram_shadow_protect_ctrl;
          `BSD_ADDR_BOUNDARY: o_io_rdata <= {8'h00, high_mem_protect_boundary};
          default: o_io_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------------
  reg [4:0] next_chip_sel;
  reg next_isa_route;
  reg next_write_block;
  reg [2:0] next_wait_states;
  reg low_mb;
  reg top_rom;
  reg video_hit;
  reg e_remapped;
  reg shadow_hit;
  reg [3:0] seg;

  always @* begin
    next_chip_sel = `BSD_CS_DRAM;
    next_isa_route = 1'b0;
    shadow_hit = 1'b0;
    seg = i_mem_addr[19:16];
    low_mb = (i_mem_addr[23:20] == 4'h0);
    top_rom = (i_mem_addr[23:20] == 4'hF) && (seg == 4'hF ||
              (seg == 4'hE && rom_layout_select == 2'h0));
    // Region of the video BIOS size within its segment
    video_hit = (i_mem_addr[15:14] <= video_bios_size);
    e_remapped = (shadow_select == 2'h3) ||
                 (shadow_select == 2'h0 && rom_layout_select == 2'h2);
    if (top_rom) begin
      next_chip_sel = `BSD_CS_BOOT_ROM;
    end else if (low_mb) begin
      case (seg)
        4'hC: begin
          if (shadow_select == 2'h3 && video_hit) begin
            shadow_hit = 1'b1;
          end else if (rom_layout_select == 2'h2 && video_hit) begin
            next_chip_sel = `BSD_CS_BOOT_ROM;
          end else begin
            next_chip_sel = `BSD_CS_NONE;
            next_isa_route = 1'b1;
          end
        end
        4'hD: begin
          next_chip_sel = `BSD_CS_NONE;
          next_isa_route = 1'b1;
        end
        4'hE: begin
          if (e_remapped) begin
            if (shadow_select == 2'h3 && spare_ram && i_mem_addr[15] &&
                !video_hit) begin
              next_chip_sel = `BSD_CS_DRAM;
            end else begin
              next_chip_sel = `BSD_CS_NONE;
              next_isa_route = 1'b1;
            end
          end else if (shadow_select == 2'h2) begin
            shadow_hit = 1'b1;
          end else if (rom_layout_select == 2'h0) begin
            next_chip_sel = `BSD_CS_BOOT_ROM;
          end else begin
            next_chip_sel = `BSD_CS_NONE;
            next_isa_route = 1'b1;
          end
        end
        4'hF: begin
          if (shadow_select != 2'h0) begin
            shadow_hit = 1'b1;
          end else begin
            next_chip_sel = `BSD_CS_BOOT_ROM;
          end
        end
        default: begin
          next_chip_sel = `BSD_CS_DRAM;
        end
      endcase
    end
    if (shadow_hit) begin
      next_chip_sel = `BSD_CS_DRAM;
    end
    next_write_block = i_mem_write && ((shadow_hit && shadow_wp) ||
                       (upper_protect_enable &&
                        {1'b0, i_mem_addr[23:17]} >= high_mem_protect_boundary));
    // Mode 00 never runs below one wait state
    next_wait_states = {1'b0, added_wait_states};
    if (nonpage_timing_mode == `BSD_NONPAGE_TIMING_MODE_ONE_WAIT) begin
      next_wait_states = next_wait_states + 3'h1;
    end
    if (!i_mem_write && last_was_write && !read_after_write_nowait) begin
      next_wait_states = next_wait_states + 3'h1;
    end
    if (i_mem_ems || i_mem_ilv_miss) begin
      next_wait_states = next_wait_states + 3'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // Decode outputs
  // ----------------------------------------------------------------------------
  always @(posedge i_clk) begin
    if (i_srst) begin
      o_decode_valid <= 1'b0;
      o_chip_sel <= `BSD_CS_NONE;
      o_rom_addr <= 17'h00000;
      o_isa_route <= 1'b0;
      o_write_block <= 1'b0;
      o_wait_states <= 3'h0;
      o_row_hold_half <= 1'b0;
      o_timing_fields <= 16'h0000;
      last_was_write <= 1'b0;
    end else if (i_clk_en) begin
      o_decode_valid <= i_mem_start;
      o_row_hold_half <= (nonpage_timing_mode == `BSD_NONPAGE_TIMING_MODE_ZERO_WAIT);
      o_timing_fields <= dram_nonpage_timing;
      if (i_mem_start) begin
        o_chip_sel <= next_chip_sel;
        o_rom_addr <= i_mem_addr[16:0];
        o_isa_route <= next_isa_route;
        o_write_block <= next_write_block;
        o_wait_states <= next_wait_states;
        last_was_write <= i_mem_write;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // DMA and bus-master RAS timing
  // ----------------------------------------------------------------------------
  bsd_delay_line u_delay (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_clk_en(i_clk_en),
    .i_ref_clk_14m(i_ref_clk_14m),
    .i_strobe(i_memr_active | i_memw_active),
    .o_ras(ras_raw),
    .o_tap(tap_unused)
  );

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_dma_ras <= 1'b0;
    end else if (i_clk_en) begin
      o_dma_ras <= ras_raw;
    end
  end

  // ----------------------------------------------------------------------------
  // Mouse activity and speed boost
  // ----------------------------------------------------------------------------
  reg mouse_now;

  always @* begin
    case (mouse_wake_select)
      2'h1: mouse_now = i_mouse_int12;
      2'h2: mouse_now = i_mouse_int4;
      2'h3: mouse_now = i_mouse_int3;
      default: mouse_now = 1'b0;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      mouse_q <= 1'b0;
      o_mouse_activity <= 1'b0;
      o_speed_boost <= 1'b0;
      boost_cnt <= 32'h00000000;
    end else if (i_clk_en) begin
      mouse_q <= mouse_now;
      o_mouse_activity <= mouse_now && !mouse_q;
      if (mouse_now && !mouse_q && i_auto_speed_switch) begin
        boost_cnt <= BOOST_CYCLES;
        o_speed_boost <= 1'b1;
      end else if (boost_cnt > 32'h00000001) begin
        boost_cnt <= boost_cnt - 32'h00000001;
      end else begin
        boost_cnt <= 32'h00000000;
        o_speed_boost <= 1'b0;
      end
    end
  end

endmodule // bsd_shadow_decode

// File: testbench/bsd_shadow_decode_sva.sv
`timescale 1ns/1ps
module bsd_shadow_decode_sva (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Inputs watched
  input wire i_clk_en,
  input wire i_io_rd,
  input wire i_mem_start,
  input wire [23:0] i_mem_addr,
  input wire i_mem_write,
  input wire i_mem_ems,
  input wire i_mem_ilv_miss,
  input wire i_memr_active,
  input wire i_memw_active,
  // Outputs watched
  input wire o_io_rdata_valid,
  input wire o_decode_valid,
  input wire [4:0] o_chip_sel,
  input wire [16:0] o_rom_addr,
  input wire o_write_block,
  input wire [2:0] o_wait_states,
  input wire o_row_hold_half,
  input wire o_dma_ras,
  input wire o_speed_boost
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  // ------
  // Sequences
  // ------
  sequence s_start;
    i_mem_start && i_clk_en;
  endsequence
  sequence s_idle;
    (!i_memr_active && !i_memw_active && i_clk_en) [*3];
  endsequence
  property p_rd_answer;
    i_io_rd && i_clk_en |=> o_io_rdata_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_dec_addr;
    s_start |=> o_decode_valid && (o_rom_addr == $past(i_mem_addr[16:0]));
  endproperty
  a_dec_addr: assert property (p_dec_addr) else $error("rom address translated");
  property p_ff_rom;
    s_start ##0 (i_mem_addr[23:16] == 8'hFF) |=> o_chip_sel == 5'h00;
  endproperty
  a_ff_rom: assert property (p_ff_rom) else $error("top segment not boot rom");
  property p_rd_noblock;
    s_start ##0 !i_mem_write |=> !o_write_block;
  endproperty
  a_rd_noblock: assert property (p_rd_noblock) else $error("read blocked");
  property p_extra_wait;
    s_start ##0 (i_mem_ems || i_mem_ilv_miss) |=> o_wait_states != 3'h0;
  endproperty
  a_extra_wait: assert property (p_extra_wait) else $error("no extra wait");
  property p_mode_wait;
    o_decode_valid && !o_row_hold_half && $stable(o_row_hold_half) |-> o_wait_states != 3'h0;
  endproperty
  a_mode_wait: assert property (p_mode_wait) else $error("mode 00 zero wait");
  property p_boost;
    $rose(o_speed_boost) |-> o_speed_boost [*8];
  endproperty
  a_boost: assert property (p_boost) else $error("boost too short");
  property p_dma_low;
    s_idle |=> !o_dma_ras;
  endproperty
  a_dma_low: assert property (p_dma_low) else $error("ras held without strobe");
endmodule // bsd_shadow_decode_sva

bind bsd_shadow_decode bsd_shadow_decode_sva u_sva (.i_clk, .i_srst, .i_clk_en, .i_io_rd,
  .i_mem_start, .i_mem_addr, .i_mem_write, .i_mem_ems, .i_mem_ilv_miss, .i_memr_active,
  .i_memw_active, .o_io_rdata_valid, .o_decode_valid, .o_chip_sel, .o_rom_addr,
  .o_write_block, .o_wait_states, .o_row_hold_half, .o_dma_ras, .o_speed_boost);

// File: testbench/bsd_isa_far_model.sv
`timescale 1ns/1ps
module bsd_isa_far_model (
  // Clock and DMA request
  input wire i_clk,
  input wire i_dma_req,
  input wire i_dma_write,
  // Strobes and reference
  output reg o_memr_active,
  output reg o_memw_active,
  output reg o_ref_clk_14m
);
  // Free running oscillator, phase unrelated to i_clk
  initial begin
    o_memr_active = 1'b0;
    o_memw_active = 1'b0;
    o_ref_clk_14m = 1'b0;
    #3.1;
    forever #34.92 o_ref_clk_14m = ~o_ref_clk_14m;
  end
  // One strobe at a time, as a DMA master does
  always @(posedge i_clk) begin
    o_memr_active <= i_dma_req && !i_dma_write;
    o_memw_active <= i_dma_req && i_dma_write;
  end
endmodule // bsd_isa_far_model

// File: testbench/bsd_shadow_decode_tb.sv
`timescale 1ns/1ps
module bsd_shadow_decode_tb;
  logic i_clk, i_srst, i_clk_en, i_io_wr, i_io_rd, i_mem_start, i_mem_write, i_mem_ems;
  logic i_mem_ilv_miss, i_memr_active, i_memw_active, i_ref_clk_14m, i_auto_speed_switch;
  logic [15:0] i_io_addr, i_io_wdata, o_io_rdata, o_timing_fields;
  logic [23:0] i_mem_addr;
  logic [4:0] o_chip_sel;
  logic [16:0] o_rom_addr;
  logic [2:0] o_wait_states;
  logic [3:1] irq;
  logic o_io_rdata_valid, o_decode_valid, o_isa_route, o_write_block, o_row_hold_half;
  logic o_dma_ras, o_speed_boost, o_mouse_activity, dma_req, dma_wr, seen;
  int n_fail, tests_run, cyc, c, k, n;
  bsd_shadow_decode #(.BOOST_CYCLES(32'd20)) uut (.i_clk, .i_srst, .i_clk_en, .i_io_addr,
    .i_io_wr, .i_io_rd, .i_io_wdata, .o_io_rdata, .o_io_rdata_valid, .i_mem_start,
    .i_mem_addr, .i_mem_write, .i_mem_ems, .i_mem_ilv_miss, .o_decode_valid, .o_chip_sel,
    .o_rom_addr, .o_isa_route, .o_write_block, .o_wait_states, .o_row_hold_half,
    .o_timing_fields, .i_memr_active, .i_memw_active, .i_ref_clk_14m, .o_dma_ras,
    .i_mouse_int12(irq[1]), .i_mouse_int4(irq[2]), .i_mouse_int3(irq[3]),
    .i_auto_speed_switch, .o_speed_boost, .o_mouse_activity);
  bsd_isa_far_model far (.i_clk, .i_dma_req(dma_req), .i_dma_write(dma_wr),
    .o_memr_active(i_memr_active), .o_memw_active(i_memw_active),
    .o_ref_clk_14m(i_ref_clk_14m));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task results;
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Hang guard, well above the few hundred cycles the tests need
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      $display("MISMATCH run_cycles expected below 20000 seen %0d", cyc);
      results;
    end
  end
  task chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_wdata <= d;
    i_io_wr <= 1'b1;
    @(posedge i_clk);
    i_io_wr <= 1'b0;
  endtask
  task rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_io_addr <= a;
    i_io_rd <= 1'b1;
    @(posedge i_clk);
    i_io_rd <= 1'b0;
    #1;
    chk("rdata_valid", 24'h1, o_io_rdata_valid);
    chk("rdata", exp, o_io_rdata);
  endtask
  task mem(input logic [23:0] a, input logic w, input logic [1:0] e, input logic rom,
    input logic isa);
    @(posedge i_clk);
    i_mem_start <= 1'b1;
    i_mem_addr <= a;
    i_mem_write <= w;
    {i_mem_ilv_miss, i_mem_ems} <= e;
    @(posedge i_clk);
    i_mem_start <= 1'b0;
    #1;
    chk("decode_valid", 24'h1, o_decode_valid);
    chk("boot_rom", rom, o_chip_sel === 5'h00);
    chk("isa_route", isa, o_isa_route);
    chk("rom_addr", a[16:0], o_rom_addr);
  endtask
  initial begin
    {i_io_wr, i_io_rd, i_mem_start, i_mem_write, i_mem_ems, i_mem_ilv_miss} = 6'h00;
    {dma_req, dma_wr, i_auto_speed_switch, irq} = 6'h00;
    i_io_addr = 16'h0000;
    i_io_wdata = 16'h0000;
    i_mem_addr = 24'h000000;
    i_clk_en = 1'b1;
    i_srst = 1'b1;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(16'h4072, 16'h0000);
    rd(16'h6072, 16'h0004);
    rd(16'hC072, 16'h0000);
    rd(16'h1234, 16'h0000);
    wr(16'h4072, 16'hFFFF);
    rd(16'h4072, 16'h7F7F);
    wr(16'hC072, 16'hFFAB);
    rd(16'hC072, 16'h00AB);
    wr(16'h6072, 16'hFFFF);
    rd(16'h6072, 16'hFFBF);
    $display("test registers done");
    wr(16'h6072, 16'h0004);
    mem(24'h0F0000, 0, 0, 1, 0);
    mem(24'hFF1234, 0, 0, 1, 0);
    mem(24'h0E0000, 0, 0, 0, 1);
    wr(16'h6072, 16'h0000);
    mem(24'h0E0000, 0, 0, 1, 0);
    mem(24'hFE5678, 0, 0, 1, 0);
    wr(16'h6072, 16'h0018);
    mem(24'h0C4000, 0, 0, 1, 0);
    mem(24'h0F4000, 0, 0, 1, 0);
    mem(24'h0E0000, 0, 0, 0, 1);
    mem(24'h0EC000, 0, 0, 0, 1);
    for (c = 0; c < 4; c++) begin
      wr(16'h6072, 16'h0008 | (c << 4));
      mem(24'h0C0000 + c * 24'h4000, 0, 0, 1, 0);
      if (c < 3) mem(24'h0C4000 + c * 24'h4000, 0, 0, 0, 1);
    end
    wr(16'h6072, 16'h0398);
    mem(24'h0C0000, 0, 0, 0, 0);
    mem(24'h0E8000, 1, 0, 0, 0);
    wr(16'h6072, 16'h0318);
    mem(24'h0E8000, 0, 0, 0, 1);
    $display("test decode done");
    wr(16'hC072, 16'h0008);
    wr(16'h6072, 16'h2004);
    mem(24'h200000, 1, 0, 0, 0);
    chk("write_block", 1, o_write_block);
    mem(24'h020000, 1, 0, 0, 0);
    chk("write_block", 0, o_write_block);
    wr(16'h6072, 16'h0004);
    mem(24'h200000, 1, 0, 0, 0);
    chk("write_block", 0, o_write_block);
    $display("test protect done");
    wr(16'h4072, 16'h0000);
    mem(24'h100000, 1, 0, 0, 0);
    chk("wait_states", 1, o_wait_states);
    mem(24'h100000, 0, 0, 0, 0);
    chk("wait_states", 2, o_wait_states);
    mem(24'h100000, 0, 1, 0, 0);
    chk("wait_states", 2, o_wait_states);
    wr(16'h4072, 16'h2000);
    // Mode output follows the register one cycle after the write lands
    @(posedge i_clk);
    #1;
    chk("row_hold_half", 1, o_row_hold_half);
    mem(24'h100000, 1, 0, 0, 0);
    mem(24'h100000, 0, 0, 0, 0);
    chk("wait_states", 1, o_wait_states);
    mem(24'h100000, 0, 2, 0, 0);
    chk("wait_states", 1, o_wait_states);
    wr(16'h4072, 16'h3000);
    mem(24'h100000, 1, 0, 0, 0);
    mem(24'h100000, 0, 0, 0, 0);
    chk("wait_states", 0, o_wait_states);
    wr(16'h4072, 16'h3003);
    mem(24'h100000, 0, 0, 0, 0);
    chk("wait_states", 3, o_wait_states);
    chk("timing_fields", 24'h003003, o_timing_fields);
    $display("test waits done");
    for (c = 0; c < 2; c++) begin
      @(posedge i_clk);
      dma_wr <= c[0];
      dma_req <= 1'b1;
      seen = 1'b0;
      repeat (30) begin
        @(posedge i_clk);
        #1;
        seen = seen | o_dma_ras;
      end
      chk("dma_ras_rise", 1, seen);
      @(posedge i_clk);
      dma_req <= 1'b0;
      repeat (5) @(posedge i_clk);
      #1;
      chk("dma_ras_fall", 0, o_dma_ras);
    end
    $display("test dma done");
    @(posedge i_clk);
    i_auto_speed_switch <= 1'b1;
    for (c = 0; c < 4; c++) begin
      wr(16'h6072, 16'h0004 | c);
      for (k = 1; k < 4; k++) begin
        seen = 1'b0;
        @(posedge i_clk);
        irq[k] <= 1'b1;
        for (n = 0; n < 6; n++) begin
          @(posedge i_clk);
          if (n == 2) irq[k] <= 1'b0;
          #1;
          seen = seen | o_mouse_activity;
        end
        chk("mouse_activity", k == c, seen);
      end
    end
    wr(16'h6072, 16'h0005);
    repeat (30) @(posedge i_clk);
    irq[1] <= 1'b1;
    n = 0;
    repeat (60) @(posedge i_clk) begin
      irq[1] <= 1'b0;
      #1;
      if (o_speed_boost === 1'b1) n++;
    end
    chk("boost_cycles", 20, n);
    $display("test mouse done");
    results;
  end
endmodule // bsd_shadow_decode_tb
